// File: src/tmx_timer_ctl.sv
// timer 0/1 mode 0 control, external interrupt detection and register access
`timescale 1ns/1ps
module tmx_timer_ctl
    import tmx_pkg::*;
#(
    parameter int DIV_SLOW = DIV_SLOW_DEF, // cpu cycles per slow timer tick
    parameter int DIV_FAST = DIV_FAST_DEF  // cpu cycles per fast timer tick
) (
    input  wire logic       clk_sys,
    input  wire logic       reset,
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr_en,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    input  wire logic       ext_irq0_pin,
    input  wire logic       ext_irq1_pin,
    input  wire logic       timer0_count_pin,
    input  wire logic       timer1_count_pin,
    input  wire logic       timer0_vector_ack,
    input  wire logic       timer1_vector_ack,
    input  wire logic       ext_irq0_vector_ack,
    input  wire logic       ext_irq1_vector_ack,
    output logic            timer0_overflow_flag,
    output logic            timer1_overflow_flag,
    output logic            ext_irq0_flag,
    output logic            ext_irq1_flag,
    output logic            timer0_overflow_pulse,
    output logic            timer1_overflow_pulse
);
    // divider counters are four bits wide
    initial begin
        if (DIV_FAST < 2 || DIV_SLOW <= DIV_FAST || DIV_SLOW > 16) begin
            $error("divider ratios out of range");
        end
    end

    localparam logic [3:0] SLOW_LAST = 4'(DIV_SLOW - 1);
    localparam logic [3:0] FAST_LAST = 4'(DIV_FAST - 1);

    typedef struct packed {
        logic [1:0] run;    // timer run bits
        logic [1:0] itype;  // irq type selects
        logic [1:0] iflag;  // irq flags
        logic [7:0] tmode;  // timer mode register
        logic [1:0] tfast;  // prescale fast bits
        logic [3:0] meta;   // first synchroniser stage
        logic [3:0] sync;   // second synchroniser stage
        logic [3:0] prev;   // delayed for edge detect
        logic [3:0] sdiv;   // slow divider
        logic [3:0] fdiv;   // fast divider
        logic       tick12; // slow tick pulse
        logic       tick4;  // fast tick pulse
        logic [7:0] rdata;  // read data
    } tmx_ctl_t;

    tmx_ctl_t    q, d;
    logic [3:0]  fall;       // falling edges of the synchronised pins
    logic        wr_ctl;     // control register write
    logic [12:0] cnt  [2];   // timer counts
    logic [2:0]  top  [2];   // undefined top bits of low bytes
    logic [1:0]  tflag;      // timer overflow flags
    logic [1:0]  tpulse;     // timer overflow pulses
    logic [1:0]  vack;       // timer vector acknowledges

    assign fall   = q.prev & ~q.sync;
    assign wr_ctl = sfr_wr_en && (sfr_addr == ADDR_CTL);
    assign vack   = {timer1_vector_ack, timer0_vector_ack};

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        d = q;
        // all pins cross from outside: two stages, then an edge stage
        d.meta = {timer1_count_pin, timer0_count_pin, ext_irq1_pin, ext_irq0_pin};
        d.sync = q.meta; // R19
        d.prev = q.sync;
        // free running dividers make one-cycle tick pulses
        d.sdiv   = (q.sdiv == SLOW_LAST) ? 4'h0 : q.sdiv + 4'h1; // R18
        d.fdiv   = (q.fdiv == FAST_LAST) ? 4'h0 : q.fdiv + 4'h1;
        d.tick12 = (q.sdiv == SLOW_LAST);
        d.tick4  = (q.fdiv == FAST_LAST);
        // register writes
        if (wr_ctl) begin
            d.run   = {sfr_wdata[CTL_TR1], sfr_wdata[CTL_TR0]}; // R03 R04
            d.itype = {sfr_wdata[CTL_IT1], sfr_wdata[CTL_IT0]}; // R07 R10
        end
        if (sfr_wr_en && sfr_addr == ADDR_MODE) begin
            d.tmode = sfr_wdata;
        end
        if (sfr_wr_en && sfr_addr == ADDR_PRESCALE) begin
            d.tfast = sfr_wdata[PRE_T0_BIT+1:PRE_T0_BIT];
        end
        // irq0 flag
        if (q.itype[0]) begin
            // edge mode: a new edge wins over ack and software clear
            if (ext_irq0_vector_ack) begin
                d.iflag[0] = 1'b0; // R08
            end
            if (wr_ctl) begin
                d.iflag[0] = sfr_wdata[CTL_IE0];
            end
            if (fall[PIN_IRQ0]) begin
                d.iflag[0] = 1'b1; // R08
            end
        end else begin
            // level mode: writes are ignored, flag follows the pin
            d.iflag[0] = ~q.sync[PIN_IRQ0]; // R09
        end
        // irq1 flag
        if (q.itype[1]) begin
            if (ext_irq1_vector_ack) begin
                d.iflag[1] = 1'b0; // R05
            end
            if (wr_ctl) begin
                d.iflag[1] = sfr_wdata[CTL_IE1];
            end
            if (fall[PIN_IRQ1]) begin
                d.iflag[1] = 1'b1; // R05
            end
        end else begin
            d.iflag[1] = ~q.sync[PIN_IRQ1]; // R06
        end
        // read data registered; one cycle behind the address
        unique case (sfr_addr)
            ADDR_CTL:      d.rdata = {tflag[1], q.run[1], tflag[0], q.run[0],
                                      q.iflag[1], q.itype[1], q.iflag[0], q.itype[0]};
            ADDR_MODE:     d.rdata = q.tmode;
            ADDR_TL0:      d.rdata = {top[0], cnt[0][LOW_BITS-1:0]}; // R16
            ADDR_TL1:      d.rdata = {top[1], cnt[1][LOW_BITS-1:0]};
            ADDR_TH0:      d.rdata = cnt[0][12:LOW_BITS];
            ADDR_TH1:      d.rdata = cnt[1][12:LOW_BITS];
            ADDR_PRESCALE: d.rdata = {3'h0, q.tfast, 3'h0};
            default:       d.rdata = 8'h00;
        endcase
    end

    // state register
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            q       <= '0;
            q.tmode <= MODE_RESET;
            q.tfast <= PRE_RESET;
            // synchroniser starts at the pins' idle high level, so no phantom
            // low reaches the level flags or the edge detectors after reset
            q.meta  <= '1;
            q.sync  <= '1;
            q.prev  <= '1;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // the two timer channels
    for (genvar i = 0; i < 2; i++) begin : g_timer
        localparam int MB = i * MODE_FIELD_W;
        tmx_timer13 u_timer (
            .clk_sys    (clk_sys),
            .reset      (reset),
            .run        (q.run[i]),
            .gate       (q.tmode[MB+MODE_GATE]), // R13
            .count_ext  (q.tmode[MB+MODE_CT]),   // R12
            .fast       (q.tfast[i]),
            .mode       (q.tmode[MB+MODE_SEL_LSB+1:MB+MODE_SEL_LSB]),
            .tick4      (q.tick4),
            .tick12     (q.tick12),
            .ext_edge   (fall[PIN_CNT0+i]),
            .gate_pin   (q.sync[PIN_IRQ0+i]),
            .wr_low     (sfr_wr_en && sfr_addr == ADDR_TL0 + 8'(i)),
            .wr_high    (sfr_wr_en && sfr_addr == ADDR_TH0 + 8'(i)),
            .wr_flag    (wr_ctl),
            .flag_wdata (sfr_wdata[i == 0 ? CTL_TF0 : CTL_TF1]),
            .wdata      (sfr_wdata),
            .vector_ack (vack[i]),
            .count      (cnt[i]),
            .low_top    (top[i]),
            .flag       (tflag[i]),
            .pulse      (tpulse[i])
        );
    end

    assign sfr_rdata             = q.rdata;
    assign ext_irq0_flag         = q.iflag[0];
    assign ext_irq1_flag         = q.iflag[1];
    assign timer0_overflow_flag  = tflag[0];
    assign timer1_overflow_flag  = tflag[1];
    assign timer0_overflow_pulse = tpulse[0];
    assign timer1_overflow_pulse = tpulse[1];

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);

    a_fast_tick_spacing: assert property (q.tick4 |=> !q.tick4 [*3] ##1 q.tick4) // R18
        else $error("fast tick spacing wrong");
    a_slow_tick_gap: assert property (q.tick12 |=> !q.tick12 [*8]) // R18
        else $error("slow tick too soon");
    a_irq0_level: assert property (!q.itype[0] |=> q.iflag[0] == !$past(q.sync[PIN_IRQ0])) // R09
        else $error("irq0 level flag does not follow pin");
    a_irq1_level: assert property (!q.itype[1] |=> q.iflag[1] == !$past(q.sync[PIN_IRQ1])) // R06
        else $error("irq1 level flag does not follow pin");
    a_irq0_edge_set: assert property (q.itype[0] && fall[PIN_IRQ0] |=> q.iflag[0]) // R08
        else $error("irq0 edge lost");
    a_irq1_edge_set: assert property (q.itype[1] && fall[PIN_IRQ1] |=> q.iflag[1]) // R05
        else $error("irq1 edge lost");
    a_irq1_edge_ack: assert property (q.itype[1] && ext_irq1_vector_ack && !fall[PIN_IRQ1]
                                      && !wr_ctl |=> !q.iflag[1]) // R05
        else $error("irq1 flag not cleared on vectoring");
    a_ctl_readback: assert property (wr_ctl ##1 sfr_addr == ADDR_CTL
                                     |=> sfr_rdata[CTL_TR0] == $past(sfr_wdata[CTL_TR0], 2)) // R04
        else $error("run bit readback wrong");
endmodule : tmx_timer_ctl

// File: include/tmx_pkg.sv
// constants and types shared by the timer 0/1 mode 0 and external interrupt block
// What this block does
// (R01) timer1 overflow sets flag, vectoring clears it
// (R02) timer0 overflow sets flag, vectoring clears it
// (R03) timer1 counts only while its run bit set
// (R04) timer0 counts only while its run bit set
// (R05) irq1 edge mode: falling edge sets flag
// (R06) irq1 level mode: flag mirrors low pin
// (R07) irq1 type: 1 edge, 0 level
// (R08) irq0 edge mode: falling edge sets flag
// (R09) irq0 level mode: flag mirrors low pin
// (R10) irq0 type: 1 edge, 0 level
// (R11) mode 0: five low plus eight high bits
// (R12) counter/timer select picks clock or pin
// (R13) gate set: count only while irq pin high
// (R14) wrap past all ones to zero, set flag
// (R15) overflow pin pulses high one cycle
// (R16) software masks top three low byte bits
// (R17) mode bits: 13bit, 16bit, reload, split; only 13bit counts here, the other three hold the count
// (R18) internal clock divided by four or twelve
// (R19) count pins synchronised, falling edge counts
package tmx_pkg;
    // register addresses on the special function register bus
    localparam logic [7:0] ADDR_CTL      = 8'h88;
    localparam logic [7:0] ADDR_MODE     = 8'h89;
    localparam logic [7:0] ADDR_TL0      = 8'h8a;
    localparam logic [7:0] ADDR_TL1      = 8'h8b;
    localparam logic [7:0] ADDR_TH0      = 8'h8c;
    localparam logic [7:0] ADDR_TH1      = 8'h8d;
    localparam logic [7:0] ADDR_PRESCALE = 8'h8e;
    // control register bit positions
    localparam int CTL_TF1 = 7;
    localparam int CTL_TR1 = 6;
    localparam int CTL_TF0 = 5;
    localparam int CTL_TR0 = 4;
    localparam int CTL_IE1 = 3;
    localparam int CTL_IT1 = 2;
    localparam int CTL_IE0 = 1;
    localparam int CTL_IT0 = 0;
    // mode register: field of timer n starts at n * MODE_FIELD_W
    localparam int MODE_FIELD_W = 4;
    localparam int MODE_SEL_LSB = 0;
    localparam int MODE_CT      = 2;
    localparam int MODE_GATE    = 3;
    // prescale register: fast bit of timer n at PRE_T0_BIT + n
    localparam int PRE_T0_BIT   = 3;
    // reset values
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [1:0] PRE_RESET  = 2'h0;
    // mode 0 counter layout
    localparam int         LOW_BITS   = 5;
    localparam logic [12:0] CNT13_MAX = 13'h1fff;
    // divider ratios from the cpu clock
    localparam int DIV_SLOW_DEF = 12;
    localparam int DIV_FAST_DEF = 4;
    // synchronised pin indices
    localparam int PIN_IRQ0 = 0;
    localparam int PIN_IRQ1 = 1;
    localparam int PIN_CNT0 = 2;
    // timer mode encodings in mode bit order 00,01,10,11
    typedef enum logic [1:0] {
        MODE_13BIT,
        MODE_16BIT,
        MODE_8BIT_RELOAD,
        MODE_SPLIT
    } tmx_mode_t;
endpackage : tmx_pkg

// File: src/tmx_timer13.sv
// one 13-bit timer/counter channel with its overflow flag and pulse
`timescale 1ns/1ps
module tmx_timer13
    import tmx_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        run,
    input  wire logic        gate,
    input  wire logic        count_ext,
    input  wire logic        fast,
    input  wire logic [1:0]  mode,
    input  wire logic        tick4,
    input  wire logic        tick12,
    input  wire logic        ext_edge,
    input  wire logic        gate_pin,
    input  wire logic        wr_low,
    input  wire logic        wr_high,
    input  wire logic        wr_flag,
    input  wire logic        flag_wdata,
    input  wire logic [7:0]  wdata,
    input  wire logic        vector_ack,
    output logic      [12:0] count,
    output logic      [2:0]  low_top,
    output logic             flag,
    output logic             pulse
);
    typedef struct packed {
        logic [12:0] cnt;   // mode 0 count
        logic [2:0]  top;   // undefined top of low byte, kept as written
        logic        flag;  // overflow flag
        logic        pulse; // overflow pulse
    } tmx_t13_t;

    tmx_t13_t q, d;
    logic     step;   // a counting event this cycle
    logic     inc;    // count advances
    logic     wrap;   // count rolls over

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        d       = q;
        d.pulse = 1'b0;
        // source: divided clock or pin edge, gated by run and gate pin
        step = run && (!gate || gate_pin) && // R03 R04 R13
               (count_ext ? ext_edge : (fast ? tick4 : tick12)); // R12 R18 R19
        unique case (tmx_mode_t'(mode))
            MODE_13BIT:       inc = step; // R17
            // other modes are not built here; the count holds
            MODE_16BIT:       inc = 1'b0;
            MODE_8BIT_RELOAD: inc = 1'b0;
            MODE_SPLIT:       inc = 1'b0;
        endcase
        // a byte write wins over the increment in the bits it writes, so no wrap then
        wrap = inc && (q.cnt == CNT13_MAX) && !wr_low && !wr_high;
        if (inc) begin
            d.cnt = q.cnt + 13'h0001; // R11 R14
        end
        if (wrap) begin
            d.pulse = 1'b1; // R15
        end
        if (wr_low) begin
            d.cnt[LOW_BITS-1:0] = wdata[LOW_BITS-1:0]; // R11
            d.top = wdata[7:LOW_BITS];
        end
        if (wr_high) begin
            d.cnt[12:LOW_BITS] = wdata;
        end
        // flag: set wins over vector clear and software write
        if (vector_ack) begin
            d.flag = 1'b0; // R01 R02
        end
        if (wr_flag) begin
            d.flag = flag_wdata;
        end
        if (wrap) begin
            d.flag = 1'b1; // R14
        end
    end

    // state register
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign count   = q.cnt;
    assign low_top = q.top;
    assign flag    = q.flag;
    assign pulse   = q.pulse;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);

    a_count_holds: assert property (!run && !wr_low && !wr_high |=> $stable(q.cnt)) // R03
        else $error("count moved while stopped");
    a_wrap_sets: assert property (wrap |=> q.pulse && q.flag && q.cnt == 13'h0000) // R14
        else $error("wrap did not clear count and set flag");
    a_pulse_single: assert property (q.pulse |=> !q.pulse) // R15
        else $error("overflow pulse longer than one cycle");
    a_flag_vectored: assert property (vector_ack && !wrap && !wr_flag |=> !q.flag) // R01
        else $error("flag not cleared on vectoring");
endmodule : tmx_timer13

// File: test/tmx_cpu_model.sv
// behavioural cpu core and pin driver facing the timer and irq block
`timescale 1ns/1ps
module tmx_cpu_model (
    input  wire logic       clk_sys,
    output logic      [7:0] sfr_addr,
    output logic            sfr_wr_en,
    output logic      [7:0] sfr_wdata,
    input  wire logic [7:0] sfr_rdata,
    output logic      [3:0] vec_ack,   // t0, t1, irq0, irq1 vectoring pulses
    output logic      [3:0] pins       // irq0, irq1, cnt0, cnt1 pin levels
);
    ////////////////////////////////////////
    // idle bus, pins resting high as with their pull-ups
    initial begin
        sfr_addr  = 8'h00;
        sfr_wr_en = 1'b0;
        sfr_wdata = 8'h00;
        vec_ack   = 4'h0;
        pins      = 4'hf;
    end
    ////////////////////////////////////////
    // one-cycle write; data is scrambled afterwards so stale data never looks valid
    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        sfr_addr  = a;
        sfr_wdata = d;
        sfr_wr_en = 1'b1;
        @(negedge clk_sys);
        sfr_wr_en = 1'b0;
        sfr_wdata = ~d;
    endtask : sfr_write
    // address is held over two edges so the registered read data has landed
    task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_sys);
        sfr_addr = a;
        repeat (2) @(negedge clk_sys);
        d = sfr_rdata;
    endtask : sfr_read
    // cpu vectors to a service routine: one-cycle acknowledge
    task automatic vector(input int idx);
        @(negedge clk_sys);
        vec_ack[idx] = 1'b1;
        @(negedge clk_sys);
        vec_ack[idx] = 1'b0;
    endtask : vector
    task automatic set_pin(input int idx, input logic v);
        @(negedge clk_sys);
        pins[idx] = v;
    endtask : set_pin
    // slow pin toggles, each phase long enough for the two-flop synchroniser
    task automatic count_edges(input int idx, input int n);
        repeat (n) begin
            set_pin(idx, 1'b0);
            repeat (3) @(negedge clk_sys);
            set_pin(idx, 1'b1);
            repeat (3) @(negedge clk_sys);
        end
    endtask : count_edges
endmodule : tmx_cpu_model

// File: test/tb_top.sv
// self-checking bench for the timer 0/1 mode 0 and external irq block
`timescale 1ns/1ps
module tb_top;
    import tmx_pkg::*;
    localparam int W = 120;      // run window in cycles for rate checks
    logic        clk_sys;
    logic        reset;
    logic [7:0]  sfr_addr;
    logic        sfr_wr_en;
    logic [7:0]  sfr_wdata;
    logic [7:0]  sfr_rdata;
    logic [3:0]  vec_ack;        // t0, t1, irq0, irq1
    logic [3:0]  pins;           // irq0, irq1, cnt0, cnt1
    logic [5:0]  obs;            // tf0, tf1, ie0, ie1, pulse0, pulse1
    int          n_mismatch;
    int          checks_done;
    int          n_pulse0 = 0;   // cycles seen with overflow pulse high
    int          n_pulse1 = 0;
    int          base;           // pulse count at the start of a scenario
    // registers with an all-zero reset value, plus one unmapped address
    logic [7:0]  rd_addr_list [4] = '{ADDR_CTL, ADDR_MODE, ADDR_PRESCALE, 8'h90};
    logic [7:0]  rd;
    logic [12:0] cnt;
    logic [12:0] cnt_b;
    ////////////////////////////////////////
    // 250 MHz clock
    initial clk_sys = 1'b0;
    always #2 clk_sys = ~clk_sys;
    tmx_timer_ctl dut (
        .clk_sys(clk_sys), .reset(reset), .sfr_addr(sfr_addr), .sfr_wr_en(sfr_wr_en),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .ext_irq0_pin(pins[0]), .ext_irq1_pin(pins[1]),
        .timer0_count_pin(pins[2]), .timer1_count_pin(pins[3]), .timer0_vector_ack(vec_ack[0]),
        .timer1_vector_ack(vec_ack[1]), .ext_irq0_vector_ack(vec_ack[2]), .ext_irq1_vector_ack(vec_ack[3]),
        .timer0_overflow_flag(obs[0]), .timer1_overflow_flag(obs[1]), .ext_irq0_flag(obs[2]),
        .ext_irq1_flag(obs[3]), .timer0_overflow_pulse(obs[4]), .timer1_overflow_pulse(obs[5]));
    tmx_cpu_model cpu (
        .clk_sys(clk_sys), .sfr_addr(sfr_addr), .sfr_wr_en(sfr_wr_en), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .vec_ack(vec_ack), .pins(pins));
    // pulse width counters, sampled mid-cycle where the pulse has settled
    always @(negedge clk_sys) begin
        if (obs[4] === 1'b1) n_pulse0 <= n_pulse0 + 1;
        if (obs[5] === 1'b1) n_pulse1 <= n_pulse1 + 1;
    end
    ////////////////////////////////////////
    // comparisons and closing report
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : finish_test
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // range compare; an unknown count makes the test non-one and fails
    task automatic check_rng(input logic [12:0] got, input logic [12:0] lo, input logic [12:0] hi);
        checks_done++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            n_mismatch++;
            $display("BAD at %0t: count %h outside %h..%h", $time, got, lo, hi);
        end
    endtask : check_rng
    // bounded wait on one observed flag; running out ends the run
    task automatic wait_obs(input int idx, input logic v, input int lim);
        int k;
        k = 0;
        while (obs[idx] !== v && k < lim) begin
            @(negedge clk_sys);
            k++;
        end
        check({7'h0, obs[idx]}, {7'h0, v});
        if (obs[idx] !== v) finish_test();
    endtask : wait_obs
    task automatic read_cnt(input int t, output logic [12:0] c);
        logic [7:0] lo;
        logic [7:0] hi;
        cpu.sfr_read(t ? ADDR_TL1 : ADDR_TL0, lo);
        cpu.sfr_read(t ? ADDR_TH1 : ADDR_TH0, hi);
        c = {hi, lo[4:0]};
    endtask : read_cnt
    ////////////////////////////////////////
    // main sequence
    initial begin
        n_mismatch = 0;
        checks_done = 0;
        reset = 1'b1;
        repeat (4) @(negedge clk_sys);
        reset = 1'b0;
        repeat (8) @(negedge clk_sys);
        // reset values, unmapped address refuses writes
        cpu.sfr_write(8'h90, 8'ha5);
        foreach (rd_addr_list[j]) begin
            cpu.sfr_read(rd_addr_list[j], rd);
            check(rd, 8'h00);
        end
        // level mode is the reset type: flag follows the low pin, writes ignored
        for (int i = 0; i < 2; i++) begin
            cpu.set_pin(i, 1'b0);
            wait_obs(2 + i, 1'b1, 8);
            cpu.sfr_write(ADDR_CTL, 8'h00);
            cpu.sfr_read(ADDR_CTL, rd);
            check(rd, 8'h02 << (2 * i));
            cpu.set_pin(i, 1'b1);
            wait_obs(2 + i, 1'b0, 8);
            cpu.sfr_write(ADDR_CTL, 8'h0a);
            cpu.sfr_read(ADDR_CTL, rd);
            check(rd, 8'h00);
        end
        // edge mode: falling edge latches, vectoring and software clear
        cpu.sfr_write(ADDR_CTL, 8'h05);
        for (int i = 0; i < 2; i++) begin
            cpu.set_pin(i, 1'b0);
            wait_obs(2 + i, 1'b1, 8);
            cpu.set_pin(i, 1'b1);
            repeat (6) @(negedge clk_sys);
            check({7'h0, obs[2 + i]}, 8'h01);
            cpu.vector(2 + i);
            check({7'h0, obs[2 + i]}, 8'h00);
            cpu.set_pin(i, 1'b0);
            cpu.set_pin(i, 1'b1);
            wait_obs(2 + i, 1'b1, 8);
            cpu.sfr_write(ADDR_CTL, 8'h05);
            cpu.sfr_read(ADDR_CTL, rd);
            check(rd, 8'h05);
        end
        // timer 0 fast tick across the 13-bit rollover
        cpu.sfr_write(ADDR_PRESCALE, 8'h08);
        cpu.sfr_write(ADDR_TL0, 8'h1e);
        cpu.sfr_write(ADDR_TH0, 8'hff);
        base = n_pulse0;
        cpu.sfr_write(ADDR_CTL, 8'h15);
        wait_obs(4, 1'b1, 40);
        check({7'h0, obs[0]}, 8'h01);
        cpu.sfr_write(ADDR_CTL, 8'h25);
        check(8'(n_pulse0 - base), 8'h01);
        read_cnt(0, cnt);
        check_rng(cnt, 13'h0, 13'h3);
        cpu.vector(0);
        check({7'h0, obs[0]}, 8'h00);
        // tick rates fast then slow, and the count holds once stopped
        for (int f = 0; f < 2; f++) begin
            cpu.sfr_write(ADDR_PRESCALE, f ? 8'h00 : 8'h08);
            cpu.sfr_write(ADDR_TL0, 8'h00);
            cpu.sfr_write(ADDR_TH0, 8'h00);
            cpu.sfr_write(ADDR_CTL, 8'h15);
            repeat (W - 2) @(negedge clk_sys);
            cpu.sfr_write(ADDR_CTL, 8'h05);
            read_cnt(0, cnt);
            check_rng(cnt, 13'(W / (f ? DIV_SLOW_DEF : DIV_FAST_DEF) - 1),
                      13'(W / (f ? DIV_SLOW_DEF : DIV_FAST_DEF) + 1));
            repeat (50) @(negedge clk_sys);
            read_cnt(0, cnt_b);
            check_rng(cnt_b, cnt, cnt);
        end
        // modes 01, 10 and 11 are not built: a running timer 0 holds its count
        for (int m = 1; m < 4; m++) begin
            cpu.sfr_write(ADDR_MODE, 8'(m));
            cpu.sfr_write(ADDR_CTL, 8'h15);
            repeat (40) @(negedge clk_sys);
            cpu.sfr_write(ADDR_CTL, 8'h05);
            read_cnt(0, cnt_b);
            check_rng(cnt_b, cnt, cnt);
        end
        // timer 1 counting pin edges: low-byte carry, then rollover
        cpu.sfr_write(ADDR_MODE, 8'h40);
        for (int i = 0; i < 2; i++) begin
            cpu.sfr_write(ADDR_TL1, i ? 8'h1d : 8'hfe);
            cpu.sfr_write(ADDR_TH1, i ? 8'hff : 8'h00);
            base = n_pulse1;
            cpu.sfr_write(ADDR_CTL, 8'h45);
            cpu.count_edges(3, i ? 5 : 3);
            cpu.sfr_write(ADDR_CTL, {obs[1], 7'h05});
            read_cnt(1, cnt);
            check_rng(cnt, i ? 13'h2 : 13'h21, i ? 13'h2 : 13'h21);
            check({7'h0, obs[1]}, 8'(i));
            check(8'(n_pulse1 - base), 8'(i));
        end
        cpu.vector(1);
        check({7'h0, obs[1]}, 8'h00);
        // gate: edges counted only while irq1 pin is high; stopped timer holds
        cpu.sfr_write(ADDR_MODE, 8'hc0);
        cpu.sfr_read(ADDR_MODE, rd);
        check(rd, 8'hc0);
        cpu.sfr_write(ADDR_TL1, 8'h00);
        cpu.sfr_write(ADDR_TH1, 8'h00);
        cpu.set_pin(1, 1'b0);
        cpu.sfr_write(ADDR_CTL, 8'h45);
        cpu.count_edges(3, 4);
        cpu.set_pin(1, 1'b1);
        repeat (4) @(negedge clk_sys);
        cpu.count_edges(3, 2);
        cpu.sfr_write(ADDR_CTL, 8'h05);
        cpu.count_edges(3, 3);
        read_cnt(1, cnt);
        check_rng(cnt, 13'h2, 13'h2);
        finish_test();
    end
endmodule : tb_top
